// >>> pll_regs.svh
// Constants for the serial-loaded PLL divider core.
// Assumes a single 20 MHz system clock; serial pins and the VCO input are
// asynchronous and are synchronised inside the core.
`ifndef PLL_REGS_SVH
`define PLL_REGS_SVH
`define REF_DIV_W 16
`define MAIN_DIV_W 10
`define SHIFT_W 17
`define CTRL_BIT_POS 0
`define REF_DIV_RESET 16'hffff
`define MAIN_DIV_RESET 10'h3ff
`define DIV_MIN 5
`define CLOCK_NS 50
`define LOCK_PULSE_NS 200
`define LOCK_PULSE_CYC ((`LOCK_PULSE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// >>> pll_pkg.sv
// Types shared by the PLL divider core.
// Assumes the constants header is included by each user.
package pll_pkg;
  typedef struct packed {
    logic clk;
    logic data;
    logic load;
    logic vco;
  } pin_in_t;
  typedef struct packed {
    logic out;
    logic oe;
  } tri_pin_t;
  typedef enum logic [1:0] {PH_EQUAL, PH_UP, PH_DOWN} phase_t;
endpackage

// >>> pll_divider.sv
// One programmable divider: one output pulse per factor input events.
// Assumes count_en_i is a one-cycle event in the clock domain.
`timescale 1ns/1ps
module pll_divider #(
  parameter int WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic count_en_i,
  input wire logic [WIDTH-1:0] factor_i,
  output logic tick_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } div_state_t;
  div_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (count_en_i) begin
      if (s_q.cnt >= factor_i - WIDTH'(1)) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

  tick_rate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $past(ce_i) && s_q.tick |-> $past(count_en_i))
    else $error("divider tick without input event");
endmodule // pll_divider

// >>> pll_core.sv
// PLL digital core: serial loader, dividers, phase compare, lock flag.
// Assumes serial pins, load strobe and VCO input are asynchronous pins.
`timescale 1ns/1ps
`include "pll_regs.svh"
module pll_core #(
  parameter int REF_W = `REF_DIV_W,
  parameter int MAIN_W = `MAIN_DIV_W,
  parameter int LOCK_CYC = `LOCK_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic vco_i,
  input wire logic osc_amp_in_i,
  output logic osc_amp_out_o,
  output logic passive_out_o,
  output logic passive_oe_o,
  output logic active_out_o,
  output logic active_oe_o,
  output logic lock_indicator_o,
  output logic div_monitor_out_o,
  output logic ref_monitor_out_o
);
  localparam int SW = REF_W + 1;

  typedef struct packed {
    pll_pkg::pin_in_t s1;
    pll_pkg::pin_in_t s2;
    pll_pkg::pin_in_t s3;
    logic clk_f;
    logic vco_f;
    logic [SW-1:0] shift;
    logic [REF_W-1:0] ref_lat;
    logic [MAIN_W-1:0] main_lat;
    pll_pkg::phase_t phase;
    logic ref_mon;
    logic div_mon;
    logic osc;
    logic locked;
    logic [7:0] lock_cnt;
    logic [7:0] low_cnt;
  } core_state_t;

  core_state_t s_q, s_d;
  logic ref_tick, div_tick;
  logic ser_rise, vco_rise, load_hi;
  pll_pkg::tri_pin_t pas, act;

  ////////////////////////////////////////////////////////////////////////
  // Pin edges and load level, valid once the second and third stages agree
  assign ser_rise = s_q.s2.clk && s_q.s3.clk && !s_q.clk_f;
  assign vco_rise = s_q.s2.vco && s_q.s3.vco && !s_q.vco_f;
  assign load_hi = s_q.s2.load && s_q.s3.load;

  ////////////////////////////////////////////////////////////////////////
  // Dividers
  pll_divider #(.WIDTH(REF_W)) u_ref_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .count_en_i(1'b1),
    .factor_i(s_q.ref_lat),
    .tick_o(ref_tick)
  );

  pll_divider #(.WIDTH(MAIN_W)) u_main_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .count_en_i(vco_rise),
    .factor_i(s_q.main_lat),
    .tick_o(div_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.s1 = '{clk: ser_clk_i, data: ser_data_i, load: load_strobe_i,
               vco: vco_i};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.osc = ~osc_amp_in_i;
    if (s_q.s2.clk == s_q.s3.clk) begin
      s_d.clk_f = s_q.s3.clk;
    end
    if (s_q.s2.vco == s_q.s3.vco) begin
      s_d.vco_f = s_q.s3.vco;
    end
    if (ser_rise) begin
      s_d.shift = {s_q.shift[SW-2:0], s_q.s3.data};
    end
    // Level-sensitive copy; last bit in decides target
    if (load_hi) begin
      if (s_q.shift[`CTRL_BIT_POS]) begin
        s_d.ref_lat = s_q.shift[SW-1:1];
      end else begin
        s_d.main_lat = s_q.shift[MAIN_W:1];
      end
    end
    // Monitors toggle per divider tick: 50% duty copy of each output
    if (ref_tick) begin
      s_d.ref_mon = ~s_q.ref_mon;
    end
    if (div_tick) begin
      s_d.div_mon = ~s_q.div_mon;
    end
    // Phase compare: whichever divider fires first steers until other does
    unique case (s_q.phase)
      pll_pkg::PH_EQUAL: begin
        if (ref_tick && !div_tick) begin
          s_d.phase = pll_pkg::PH_UP;
        end else if (div_tick && !ref_tick) begin
          s_d.phase = pll_pkg::PH_DOWN;
        end
      end
      pll_pkg::PH_UP: begin
        if (div_tick) begin
          s_d.phase = pll_pkg::PH_EQUAL;
        end
      end
      pll_pkg::PH_DOWN: begin
        if (ref_tick) begin
          s_d.phase = pll_pkg::PH_EQUAL;
        end
      end
      default: s_d.phase = pll_pkg::PH_EQUAL;
    endcase
    // Lock: error pulse longer than window drops lock and pulses low
    if (s_q.phase != pll_pkg::PH_EQUAL) begin
      if (s_q.lock_cnt != 8'(LOCK_CYC)) begin
        s_d.lock_cnt = s_q.lock_cnt + 8'h01;
      end else begin
        s_d.low_cnt = 8'(LOCK_CYC);
      end
    end else begin
      s_d.lock_cnt = 8'h00;
    end
    if (s_q.low_cnt != 8'h00) begin
      s_d.low_cnt = s_q.low_cnt - 8'h01;
    end
    s_d.locked = (s_q.low_cnt == 8'h00);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{ref_lat: `REF_DIV_RESET, main_lat: `MAIN_DIV_RESET,
               phase: pll_pkg::PH_EQUAL, default: '0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge-pump pins
  always_comb begin
    pas = '{out: 1'b0, oe: 1'b0};
    act = '{out: 1'b0, oe: 1'b0};
    unique case (s_q.phase)
      pll_pkg::PH_UP: begin
        pas = '{out: 1'b1, oe: 1'b1};
        act = '{out: 1'b0, oe: 1'b1};
      end
      pll_pkg::PH_DOWN: begin
        pas = '{out: 1'b0, oe: 1'b1};
        act = '{out: 1'b1, oe: 1'b1};
      end
      default: begin
        pas = '{out: 1'b0, oe: 1'b0};
        act = '{out: 1'b0, oe: 1'b0};
      end
    endcase
  end

  assign passive_out_o = pas.out;
  assign passive_oe_o = pas.oe;
  assign active_out_o = act.out;
  assign active_oe_o = act.oe;
  assign lock_indicator_o = s_q.locked;
  assign div_monitor_out_o = s_q.div_mon;
  assign ref_monitor_out_o = s_q.ref_mon;
  assign osc_amp_out_o = s_q.osc;

  ////////////////////////////////////////////////////////////////////////
  sequence ser_edge_s;
    ce_i && ser_rise;
  endsequence

  shift_in_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ser_edge_s |=> s_q.shift[0] == $past(s_q.s3.data))
    else $error("serial bit not shifted");
  ref_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && load_hi && s_q.shift[0]
    |=> s_q.ref_lat == $past(s_q.shift[SW-1:1]))
    else $error("reference latch not loaded");
  main_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && load_hi && !s_q.shift[0]
    |=> s_q.main_lat == $past(s_q.shift[MAIN_W:1]))
    else $error("main latch not loaded");
  ctrl_select_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && load_hi && !s_q.shift[0] |=> $stable(s_q.ref_lat))
    else $error("wrong latch written");
  passive_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.phase == pll_pkg::PH_UP |-> passive_oe_o && passive_out_o)
    else $error("passive output not high");
  passive_sink_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.phase == pll_pkg::PH_DOWN |-> passive_oe_o && !passive_out_o)
    else $error("passive output not low");
  active_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.phase == pll_pkg::PH_UP |-> active_oe_o && !active_out_o)
    else $error("active output not low");
  ref_mon_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && ref_tick |=> ref_monitor_out_o != $past(ref_monitor_out_o))
    else $error("reference monitor missed tick");
  div_mon_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && div_tick |=> div_monitor_out_o != $past(div_monitor_out_o))
    else $error("divider monitor missed tick");
  lock_drop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.low_cnt != 8'h00 |=> !lock_indicator_o)
    else $error("lock indicator high while unlocked");
  active_sink_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.phase == pll_pkg::PH_DOWN |-> active_oe_o && active_out_o)
    else $error("active output not high");
  pins_float_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_q.phase == pll_pkg::PH_EQUAL |-> !passive_oe_o && !active_oe_o)
    else $error("filter outputs not floating");
endmodule // pll_core

// >>> pll_host_model.sv
// Host controller model that shifts divider words into the PLL core.
// Assumes the system clock paces every pin change; serial clock idles low.
`timescale 1ns/1ps
module pll_host_model (
  input wire logic clock_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic pulse_clk(input int pace);
    hold(pace);
    ser_clk_o <= 1'b1;
    hold(pace);
    ser_clk_o <= 1'b0;
  endtask

  // Pace sets the half period in system cycles, so a slow host is one call
  task automatic send_word(input logic ctrl, input logic [15:0] value,
                           input int pace);
    int bits;
    bits = ctrl ? 16 : 10;
    for (int i = bits - 1; i >= 0; i--) begin
      ser_data_o <= value[i];
      pulse_clk(pace);
    end
    ser_data_o <= ctrl;
    pulse_clk(pace);
    hold(pace);
    // Released data line must not keep the last level
    ser_data_o <= ~ctrl;
    load_strobe_o <= 1'b1;
    hold(pace);
    load_strobe_o <= 1'b0;
    hold(pace);
  endtask
endmodule // pll_host_model

// >>> tb_pll_serial_divider_load.sv
// Bench for the PLL core: loads both dividers, times the monitors, pins.
// Assumes a 20 MHz clock and the host model driving the serial pins.
`timescale 1ns/1ps
module tb_pll_serial_divider_load;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic vco_i = 1'b0;
  logic osc_i = 1'b0;
  logic ser_clk, ser_data, strobe, p_out, p_oe, a_out, a_oe;
  logic lock, div_mon, ref_mon;
  logic lock_low = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int vcnt = 0;
  int gap;
  int r;
  int n;
  int ref_q[$];
  int main_q[$];
  // Model phase: 0 level, 1 reference ahead, 2 main divider ahead
  int ph_m = 0;
  int up_cyc = 0;
  int dn_cyc = 0;
  logic ref_m = 1'b0;
  logic div_m = 1'b0;
  logic [3:0] pins_seen;
  assign pins_seen = {p_oe, p_out, a_oe, a_out};

  always #25 clock_i = ~clock_i;
  // VCO runs three cycles high, three low
  always @(posedge clock_i) begin
    vcnt <= (vcnt + 1) % 6;
    vco_i <= (vcnt < 3);
    osc_i <= 1'($urandom);
  end
  always @(negedge clock_i) if (lock === 1'b0) lock_low <= 1'b1;
  // Monitors move on the same edge as the phase, so they feed the model
  always @(negedge clock_i) begin
    if (rst_n_i === 1'b1) begin
      if (ph_m == 0 && ref_mon !== ref_m && div_mon === div_m) ph_m = 1;
      else if (ph_m == 0 && div_mon !== div_m && ref_mon === ref_m) ph_m = 2;
      else if (ph_m == 1 && div_mon !== div_m) ph_m = 0;
      else if (ph_m == 2 && ref_mon !== ref_m) ph_m = 0;
      if (ph_m == 1) up_cyc++;
      if (ph_m == 2) dn_cyc++;
      check("charge_pins", 32'(pins_seen), 32'(pins_exp(ph_m)));
    end else begin
      ph_m = 0;
    end
    ref_m = ref_mon;
    div_m = div_mon;
  end

  pll_host_model pll_host_model_i (.clock_i(clock_i), .ser_clk_o(ser_clk),
    .ser_data_o(ser_data), .load_strobe_o(strobe));
  pll_core pll_core_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .ser_clk_i(ser_clk), .ser_data_i(ser_data), .load_strobe_i(strobe),
    .vco_i(vco_i), .osc_amp_in_i(osc_i), .osc_amp_out_o(),
    .passive_out_o(p_out), .passive_oe_o(p_oe), .active_out_o(a_out),
    .active_oe_o(a_oe), .lock_indicator_o(lock),
    .div_monitor_out_o(div_mon), .ref_monitor_out_o(ref_mon));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  // Pins as {passive oe, passive out, active oe, active out}
  function automatic logic [3:0] pins_exp(input int ph);
    if (ph == 1) return 4'he;
    if (ph == 2) return 4'hb;
    return 4'h0;
  endfunction

  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Cycles until the chosen monitor changes; bounded
  task automatic toggle(input bit sel, input int lim, output int cnt);
    logic p;
    p = sel ? ref_mon : div_mon;
    cnt = 0;
    do begin
      @(negedge clock_i);
      cnt++;
    end while ((sel ? ref_mon : div_mon) === p && cnt < lim);
    if (cnt >= lim) begin
      errors++;
      final_report();
    end
  endtask

  // First gap may still run on the old factor, so the third is measured
  task automatic run_case(input int rf, input int mf, input bit ref_fast);
    logic [3:0] pe;
    ref_q.push_back(rf);
    main_q.push_back(mf);
    pll_host_model_i.send_word(1'b0, 16'(mf), 5);
    pll_host_model_i.send_word(1'b1, 16'(rf), 9);
    lock_low = 1'b0;
    up_cyc = 0;
    dn_cyc = 0;
    repeat (3) toggle(1'b1, 70000, gap);
    check("ref_period", gap, ref_q.pop_front());
    repeat (3) toggle(1'b0, 8000, gap);
    check("div_period", gap, 6 * main_q.pop_front());
    toggle(ref_fast, 8000, gap);
    repeat (3) @(negedge clock_i);
    // Let the phase model settle first
    #1;
    pe = pins_exp(ph_m);
    check("passive_pin", 32'(pins_seen[3:2]), 32'(pe[3:2]));
    check("active_pin", 32'(pins_seen[1:0]), 32'(pe[1:0]));
    check("lead_side", 32'(up_cyc > dn_cyc), 32'(ref_fast));
    check("lock_pulsed", 32'(lock_low), 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5f22064b));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    r = 5 + $urandom % 16;
    n = 100 + $urandom % 101;
    run_case(r, n, 1'b1);
    r = 200 + $urandom % 201;
    run_case(r, 5, 1'b0);
    final_report();
  end
endmodule // tb_pll_serial_divider_load
